/* File: secure_twi_pkg.sv */
// Shared constants and types for the two-wire target framing block.
// Assumes a 250 MHz core clock and an 8-bit serial word on the link.
package secure_twi_pkg;

   localparam int WORD_BITS = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int READ_BIT = 0;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam int FIFO_DEPTH = 4;

   // Write cycle limit in milliseconds and the core clock rate in MHz.
   localparam int T_WR_MS = 5;
   localparam int CORE_MHZ = 250;
   localparam int US_PER_MS = 1000;
   localparam int WR_CYCLES = T_WR_MS * US_PER_MS * CORE_MHZ;
   localparam int WR_CNT_W = 21;

   typedef struct packed {
      logic first;
      logic [WORD_BITS-1:0] data;
   } word_type;

   localparam int WORD_W = $bits(word_type);

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_RX = 3'h1,
      S_RX_ACK = 3'h2,
      S_TX = 3'h3,
      S_TX_ACK = 3'h4,
      S_WAIT = 3'h5
   } link_state_type;

endpackage

/* File: twi_word_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module twi_word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic in_rdy_q, in_rdy_d, out_vld_q, out_vld_d;
   logic push, pop;

   always_comb begin
      push = i_in_valid & in_rdy_q;
      pop = out_vld_q & i_out_ready;
      wr_d = push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
      rd_d = pop ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q + CW'(push) - CW'(pop);
      in_rdy_d = (cnt_d != FULL);
      out_vld_d = (cnt_d != '0);
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_rdy_q <= 1'b0;
         out_vld_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         in_rdy_q <= in_rdy_d;
         out_vld_q <= out_vld_d;
      end
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   assign o_in_ready = in_rdy_q;
   assign o_out_valid = out_vld_q;
   assign o_out_data = mem_q[rd_q];
endmodule // twi_word_fifo
`default_nettype wire

/* File: secure_twi_target.sv */
// Two-wire target framing: start/stop detection, 8-bit words, acknowledge,
// standby after reads and the self-timed write cycle timer.
// Assumes an external pull-up on the data line and an oversampling link
// clock several times faster than the serial clock.
// Contract
// - Data changes while clock high mean start/stop.
// - Falling data with clock high starts transfer.
// - Rising data with clock high ends sequence.
// - Stop after read enters standby.
// - Every word is shifted as eight bits.
// - Pull data low in ninth clock to acknowledge.
// - Write cycle ends within 5 ms of stop.
// - Sample on rising clock, launch on falling.
// - Data line is only pulled low or released.
`timescale 1ns/100ps
`default_nettype none
module secure_twi_target
   import secure_twi_pkg::*;
#(
   parameter int WR_LIMIT = secure_twi_pkg::WR_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda_in,
   output logic o_sda_out,
   output logic o_sda_oe,
   output logic o_rx_valid,
   output secure_twi_pkg::word_type o_rx_word,
   input wire logic i_rx_ready,
   input wire logic i_rd_valid,
   input wire logic [secure_twi_pkg::WORD_BITS-1:0] i_rd_data,
   output logic o_rd_ready,
   output logic o_write_busy,
   output logic o_standby
);
   import secure_twi_pkg::*;
   localparam logic [WR_CNT_W-1:0] WR_END = WR_CNT_W'(WR_LIMIT - 1);
   // Link domain: pin synchronisers, framing state and the shift registers.
   logic rst_meta_q, rst_l_q;
   logic scl_meta_q, scl_q, scl_old_q;
   logic sda_meta_q, sda_q, sda_old_q;
   logic busy_meta_q, busy_s_q, space_meta_q, space_s_q;
   logic hold_meta_q, hold_s_q, hold_old_q;
   link_state_type st_q, st_d;
   logic [2:0] bcnt_q, bcnt_d;
   logic [WORD_BITS-1:0] sh_q, sh_d, tx_q, tx_d, rx_q, rx_d;
   logic [WORD_BITS-1:0] rd_byte_q, rd_byte_d;
   logic phase_q, phase_d, ack_q, ack_d, first_q, first_d;
   logic rd_mode_q, rd_mode_d, was_wr_q, was_wr_d, oe_q, oe_d;
   logic standby_q, standby_d, rx_first_q, rx_first_d;
   logic rx_tgl_q, rx_tgl_d, wr_tgl_q, wr_tgl_d;
   logic have_rd_q, have_rd_d, take_tgl_q, take_tgl_d;
   logic scl_rise, scl_fall, start_ev, stop_ev, load_tx;
   logic [WORD_BITS-1:0] byte_in;
   // Core-domain registers read by the link side: hold_q under handshake, busy_q and fifo_in_ready via synchronisers.
   logic [WORD_BITS-1:0] hold_q, hold_d;
   logic hold_tgl_q, hold_tgl_d, busy_q, busy_d, fifo_in_ready;

   always_ff @(posedge i_link_clk) begin
      rst_meta_q <= i_srst;
      rst_l_q <= rst_meta_q;
      scl_meta_q <= i_scl;
      scl_q <= scl_meta_q;
      scl_old_q <= scl_q;
      sda_meta_q <= i_sda_in;
      sda_q <= sda_meta_q;
      sda_old_q <= sda_q;
      busy_meta_q <= busy_q;
      busy_s_q <= busy_meta_q;
      space_meta_q <= fifo_in_ready;
      space_s_q <= space_meta_q;
      hold_meta_q <= hold_tgl_q;
      hold_s_q <= hold_meta_q;
      hold_old_q <= hold_s_q;
   end

   always_comb begin
      scl_rise = scl_q & ~scl_old_q;
      scl_fall = ~scl_q & scl_old_q;
      start_ev = scl_q & scl_old_q & sda_old_q & ~sda_q;
      stop_ev = scl_q & scl_old_q & ~sda_old_q & sda_q;
      byte_in = {sh_q[WORD_BITS-2:0], sda_q};
      st_d = st_q;
      bcnt_d = bcnt_q;
      sh_d = sh_q;
      tx_d = tx_q;
      rx_d = rx_q;
      rd_byte_d = rd_byte_q;
      phase_d = phase_q;
      ack_d = ack_q;
      first_d = first_q;
      rd_mode_d = rd_mode_q;
      was_wr_d = was_wr_q;
      oe_d = oe_q;
      standby_d = standby_q;
      rx_first_d = rx_first_q;
      rx_tgl_d = rx_tgl_q;
      wr_tgl_d = wr_tgl_q;
      have_rd_d = have_rd_q;
      take_tgl_d = take_tgl_q;
      load_tx = 1'b0;
      if (hold_s_q != hold_old_q) begin
         rd_byte_d = hold_q;
         have_rd_d = 1'b1;
      end
      unique case (st_q)
         S_IDLE, S_WAIT: begin
         end
         S_RX: begin
            if (scl_rise) begin
               sh_d = byte_in;
               bcnt_d = bcnt_q + 3'h1;
               if (bcnt_q == BIT_LAST) begin
                  st_d = S_RX_ACK;
                  phase_d = 1'b0;
                  if (first_q) begin
                     ack_d = ~busy_s_q
                        & (byte_in[READ_BIT] | space_s_q);
                     rd_mode_d = ~busy_s_q & byte_in[READ_BIT];
                  end else begin
                     ack_d = ~rd_mode_q & space_s_q;
                  end
                  if (ack_d && !rd_mode_d) begin
                     rx_d = byte_in;
                     rx_first_d = first_q;
                     rx_tgl_d = ~rx_tgl_q;
                     was_wr_d = 1'b1;
                  end
               end
            end
         end
         S_RX_ACK: begin
            if (scl_fall) begin
               if (!phase_q) begin
                  oe_d = ack_q;
                  phase_d = 1'b1;
               end else begin
                  oe_d = 1'b0;
                  first_d = 1'b0;
                  bcnt_d = 3'h0;
                  if (!ack_q) begin
                     st_d = S_WAIT;
                  end else if (rd_mode_q) begin
                     load_tx = 1'b1;
                  end else begin
                     st_d = S_RX;
                  end
               end
            end
         end
         S_TX: begin
            if (scl_fall) begin
               if (bcnt_q == BIT_LAST) begin
                  oe_d = 1'b0;
                  st_d = S_TX_ACK;
               end else begin
                  tx_d = {tx_q[WORD_BITS-2:0], 1'b0};
                  oe_d = ~tx_q[WORD_BITS-2];
                  bcnt_d = bcnt_q + 3'h1;
               end
            end
         end
         S_TX_ACK: begin
            if (scl_rise) begin
               ack_d = ~sda_q;
            end else if (scl_fall) begin
               if (ack_q) begin
                  load_tx = 1'b1;
               end else begin
                  st_d = S_WAIT;
               end
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
      if (load_tx) begin
         tx_d = have_rd_q ? rd_byte_q : IDLE_BYTE;
         oe_d = ~tx_d[WORD_BITS-1];
         bcnt_d = 3'h0;
         st_d = S_TX;
         if (have_rd_q) begin
            have_rd_d = 1'b0;
            take_tgl_d = ~take_tgl_q;
         end
      end
      if (start_ev) begin
         st_d = S_RX;
         bcnt_d = 3'h0;
         first_d = 1'b1;
         rd_mode_d = 1'b0;
         was_wr_d = 1'b0;
         oe_d = 1'b0;
         standby_d = 1'b0;
      end else if (stop_ev) begin
         st_d = S_IDLE;
         oe_d = 1'b0;
         if (was_wr_q) begin
            wr_tgl_d = ~wr_tgl_q;
         end
         if (rd_mode_q) begin
            standby_d = 1'b1;
         end
         was_wr_d = 1'b0;
         rd_mode_d = 1'b0;
      end
   end

   always_ff @(posedge i_link_clk) begin
      if (rst_l_q) begin
         st_q <= S_IDLE;
         bcnt_q <= 3'h0;
         sh_q <= '0;
         tx_q <= '0;
         rx_q <= '0;
         rd_byte_q <= '0;
         phase_q <= 1'b0;
         ack_q <= 1'b0;
         first_q <= 1'b0;
         rd_mode_q <= 1'b0;
         was_wr_q <= 1'b0;
         oe_q <= 1'b0;
         standby_q <= 1'b1;
         rx_first_q <= 1'b0;
         rx_tgl_q <= 1'b0;
         wr_tgl_q <= 1'b0;
         have_rd_q <= 1'b0;
         take_tgl_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bcnt_q <= bcnt_d;
         sh_q <= sh_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         rd_byte_q <= rd_byte_d;
         phase_q <= phase_d;
         ack_q <= ack_d;
         first_q <= first_d;
         rd_mode_q <= rd_mode_d;
         was_wr_q <= was_wr_d;
         oe_q <= oe_d;
         standby_q <= standby_d;
         rx_first_q <= rx_first_d;
         rx_tgl_q <= rx_tgl_d;
         wr_tgl_q <= wr_tgl_d;
         have_rd_q <= have_rd_d;
         take_tgl_q <= take_tgl_d;
      end
   end
   // The pad only ever pulls low, so the data output is a constant zero.
   logic sda_out_q;
   always_ff @(posedge i_link_clk) begin
      sda_out_q <= 1'b0;
   end
   assign o_sda_out = sda_out_q;
   assign o_sda_oe = oe_q;
   // Core domain: write cycle timer, read byte hand-over and the queue.
   logic rx_meta_q, rx_s_q, rx_old_q, wr_meta_q, wr_s_q, wr_old_q;
   logic take_meta_q, take_s_q, take_old_q, stb_meta_q, stb_s_q;
   logic [WR_CNT_W-1:0] cnt_q, cnt_d;
   logic pend_q, pend_d, rd_rdy_q, rd_rdy_d;
   logic rx_push, wr_start, taken;
   word_type rx_word;

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         rx_meta_q <= 1'b0;
         rx_s_q <= 1'b0;
         rx_old_q <= 1'b0;
         wr_meta_q <= 1'b0;
         wr_s_q <= 1'b0;
         wr_old_q <= 1'b0;
         take_meta_q <= 1'b0;
         take_s_q <= 1'b0;
         take_old_q <= 1'b0;
         stb_meta_q <= 1'b1;
         stb_s_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_tgl_q;
         rx_s_q <= rx_meta_q;
         rx_old_q <= rx_s_q;
         wr_meta_q <= wr_tgl_q;
         wr_s_q <= wr_meta_q;
         wr_old_q <= wr_s_q;
         take_meta_q <= take_tgl_q;
         take_s_q <= take_meta_q;
         take_old_q <= take_s_q;
         stb_meta_q <= standby_q;
         stb_s_q <= stb_meta_q;
      end
   end

   always_comb begin
      rx_push = rx_s_q ^ rx_old_q;
      wr_start = wr_s_q ^ wr_old_q;
      taken = take_s_q ^ take_old_q;
      rx_word.first = rx_first_q;
      rx_word.data = rx_q;
      busy_d = busy_q;
      cnt_d = cnt_q;
      if (busy_q) begin
         cnt_d = cnt_q + 1'b1;
         if (cnt_q == WR_END) begin
            busy_d = 1'b0;
         end
      end
      if (wr_start) begin
         busy_d = 1'b1;
         cnt_d = '0;
      end
      hold_d = hold_q;
      hold_tgl_d = hold_tgl_q;
      pend_d = pend_q;
      if (taken) begin
         pend_d = 1'b0;
      end
      if (i_rd_valid && rd_rdy_q) begin
         hold_d = i_rd_data;
         hold_tgl_d = ~hold_tgl_q;
         pend_d = 1'b1;
      end
      rd_rdy_d = ~pend_d;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
         hold_q <= '0;
         hold_tgl_q <= 1'b0;
         pend_q <= 1'b0;
         rd_rdy_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         cnt_q <= cnt_d;
         hold_q <= hold_d;
         hold_tgl_q <= hold_tgl_d;
         pend_q <= pend_d;
         rd_rdy_q <= rd_rdy_d;
      end
   end

   // Received words queue here; a full queue makes the link refuse the
   // next word with a missing acknowledge.
   twi_word_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .i_clk(i_core_clk),
      .i_srst(i_srst),
      .i_in_valid(rx_push),
      .i_in_data(rx_word),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(o_rx_valid),
      .o_out_data(o_rx_word),
      .i_out_ready(i_rx_ready)
   );

   assign o_rd_ready = rd_rdy_q;
   assign o_write_busy = busy_q;
   assign o_standby = stb_s_q;
endmodule // secure_twi_target
`default_nettype wire

/* File: secure_twi_target_checker.sv */
// Concurrent checks on the ports of the two-wire target.
// Assumes it is bound to the target and shares its write cycle limit.
`timescale 1ns/100ps
`default_nettype none
module secure_twi_target_checker
   import secure_twi_pkg::*;
#(
   parameter int WR_LIMIT = 200
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   input wire logic o_rx_valid,
   input wire secure_twi_pkg::word_type o_rx_word,
   input wire logic i_rx_ready,
   input wire logic i_rd_valid,
   input wire logic o_rd_ready,
   input wire logic o_write_busy,
   input wire logic o_standby
);
   import secure_twi_pkg::*;
   int busy_cnt_q;
   int busy_cnt_d;
   always_comb begin
      busy_cnt_d = o_write_busy ? busy_cnt_q + 1 : 0;
   end
   always_ff @(posedge i_core_clk) begin
      busy_cnt_q <= i_srst ? 0 : busy_cnt_d;
   end
   chk_busy_bound: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_write_busy |-> busy_cnt_q <= WR_LIMIT + 4) else $error("busy too long");
   chk_busy_min: assert property (@(posedge i_core_clk) disable iff (i_srst)
      $rose(o_write_busy) |=> o_write_busy [*8]) else $error("busy too short");
   chk_busy_standby: assert property (@(posedge i_core_clk) disable iff (i_srst)
      $rose(o_write_busy) |-> !o_standby) else $error("standby in write");
   chk_rx_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
      else $error("rx word not held");
   chk_rd_taken: assert property (@(posedge i_core_clk) disable iff (i_srst)
      o_rd_ready && i_rd_valid |=> !o_rd_ready) else $error("rd ready stayed");
   chk_drive_low: assert property (@(posedge i_link_clk) disable iff (i_srst)
      o_sda_oe |-> !o_sda_out) else $error("data line driven high");
   chk_oe_scl_low: assert property (@(posedge i_link_clk) disable iff (i_srst)
      $changed(o_sda_oe) |-> !i_scl) else $error("data changed with clock high");
   chk_oe_stands: assert property (@(posedge i_link_clk) disable iff (i_srst)
      $rose(o_sda_oe) |-> o_sda_oe [*8]) else $error("acknowledge too short");
   cover property (@(posedge i_core_clk) $rose(o_write_busy));
   cover property (@(posedge i_core_clk) $rose(o_standby));
   cover property (@(posedge i_core_clk) o_rx_valid && i_rx_ready);
   cover property (@(posedge i_link_clk) $rose(o_sda_oe));
endmodule // secure_twi_target_checker
`default_nettype wire

/* File: twi_host_model.sv */
// Bus controller model that drives the serial clock and pulls data low.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module twi_host_model (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   localparam int HALF = 1000;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic clk_bit(input logic b, output logic seen);
      o_sda_low = !b;
      #(HALF / 2);
      o_scl = 1'b1;
      #(HALF);
      seen = i_sda;
      o_scl = 1'b0;
      #(HALF / 2);
   endtask
   task automatic start();
      o_sda_low = 1'b0;
      #(HALF / 2);
      o_scl = 1'b1;
      #(HALF);
      o_sda_low = 1'b1;
      #(HALF);
      o_scl = 1'b0;
      #(HALF / 2);
   endtask
   task automatic stop();
      o_sda_low = 1'b1;
      #(HALF / 2);
      o_scl = 1'b1;
      #(HALF);
      o_sda_low = 1'b0;
      #(HALF);
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], s);
      end
      clk_bit(1'b1, s);
      ack = !s;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, d[i]);
      end
      clk_bit(!ack, s);
   endtask
endmodule // twi_host_model
`default_nettype wire

/* File: secure_twi_target_bench.sv */
// Self-checking bench for the two-wire target with a controller model.
// Assumes the package, the target, its FIFO and the checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module secure_twi_target_bench;
   import secure_twi_pkg::*;
   localparam int WR_LIMIT = 6000;
   localparam logic [7:0] WR_SEQ [5] = '{8'hA0, 8'h11, 8'h22, 8'h33, 8'h44};
   logic core_clk = 1'b0;
   logic link_clk = 1'b0;
   logic srst = 1'b1;
   logic rx_ready = 1'b1;
   logic rd_valid = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic scl, host_low, sda, sda_out, sda_oe, rx_valid, rd_ready;
   logic write_busy, standby;
   word_type rx_word;
   word_type got[$];
   int errors = 0;
   int compares = 0;
   always #2 core_clk = ~core_clk;
   always #62.5 link_clk = ~link_clk;
   // The line is pulled up unless either party pulls it low.
   assign sda = !((sda_oe && !sda_out) || host_low);
   twi_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   secure_twi_target #(.WR_LIMIT(WR_LIMIT)) dut (
      .i_core_clk(core_clk),
      .i_srst(srst),
      .i_link_clk(link_clk),
      .i_scl(scl),
      .i_sda_in(sda),
      .o_sda_out(sda_out),
      .o_sda_oe(sda_oe),
      .o_rx_valid(rx_valid),
      .o_rx_word(rx_word),
      .i_rx_ready(rx_ready),
      .i_rd_valid(rd_valid),
      .i_rd_data(rd_data),
      .o_rd_ready(rd_ready),
      .o_write_busy(write_busy),
      .o_standby(standby)
   );
   always @(posedge core_clk) begin
      if (rx_valid && rx_ready) got.push_back(rx_word);
   end
   task automatic check(input string name, input logic [8:0] e, input logic [8:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic reset_values();
      check("standby", 9'h001, 9'(standby));
      check("busy", 9'h000, 9'(write_busy));
      check("rd ready", 9'h001, 9'(rd_ready));
   endtask
   task automatic full_and_restart();
      logic a;
      logic s;
      @(posedge core_clk);
      #1 rx_ready = 1'b0;
      host.start();
      repeat (3) host.clk_bit(1'b0, s);
      host.start();
      for (int i = 0; i < 5; i++) begin
         host.send_byte(WR_SEQ[i], a);
         check("ack", 9'(i < 4), 9'(a));
      end
      host.stop();
      repeat (20) @(posedge core_clk);
      check("busy", 9'h001, 9'(write_busy));
      check("standby", 9'h000, 9'(standby));
      #1 rx_ready = 1'b1;
      repeat (10) @(posedge core_clk);
      check("count", 9'h004, 9'(got.size()));
      for (int i = 0; i < 4; i++) begin
         check("word", {i == 0, WR_SEQ[i]}, got[i]);
      end
      got.delete();
   endtask
   task automatic poll_and_read();
      logic a;
      logic [7:0] d;
      int n;
      @(posedge core_clk);
      #1 rd_valid = 1'b1;
      rd_data = 8'hC3;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (rd_ready !== 1'b1 && n < 100);
      #1 rd_valid = 1'b0;
      n = 0;
      a = 1'b0;
      while (!a && n < 6) begin
         host.start();
         host.send_byte(8'hA1, a);
         n++;
         if (!a) host.stop();
      end
      check("polls", 9'h002, 9'(n));
      check("busy", 9'h000, 9'(write_busy));
      host.recv_byte(1'b0, d);
      check("read byte", 9'h0C3, 9'(d));
      host.stop();
      repeat (20) @(posedge core_clk);
      check("standby", 9'h001, 9'(standby));
      check("count", 9'h000, 9'(got.size()));
      check("rx valid", 9'h000, 9'(rx_valid));
      check("rd ready", 9'h001, 9'(rd_ready));
   endtask
   initial begin
      repeat (4) @(posedge link_clk);
      @(posedge core_clk);
      #1 srst = 1'b0;
      repeat (3) @(posedge core_clk);
      reset_values();
      repeat (8) @(posedge link_clk);
      full_and_restart();
      poll_and_read();
      complete_run();
   end
   initial begin
      #300000;
      errors++;
      complete_run();
   end
endmodule // secure_twi_target_bench
bind secure_twi_target secure_twi_target_checker #(.WR_LIMIT(WR_LIMIT)) chk (
   .i_core_clk(i_core_clk),
   .i_srst(i_srst),
   .i_link_clk(i_link_clk),
   .i_scl(i_scl),
   .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe),
   .o_rx_valid(o_rx_valid),
   .o_rx_word(o_rx_word),
   .i_rx_ready(i_rx_ready),
   .i_rd_valid(i_rd_valid),
   .o_rd_ready(o_rd_ready),
   .o_write_busy(o_write_busy),
   .o_standby(o_standby)
);
`default_nettype wire
